// >>> shared/emb_pkg.sv
// Constants, pin-group types and state encodings of the external memory and I/O bus
// Notes on behaviour
// - The bus drives a 16-bit address, bit 0 least and bit 15 most significant, for all spaces.
// - Address pins float while float request is low and keep their last value in power-down.
// - Data pins float unless writing, and also in power-down, in reset and during float request.
// - The three space selects rest high, one goes low for its space, all float on reset/pd/float.
// - Ready sampled low during an access adds one wait cycle and is sampled again until high.
// - Read/write rests high, goes low only for a write, and floats on reset, pd and float.
// - The access strobe stays high except while it marks an external bus cycle.
// - The access strobe floats in reset, in power-down and while float is requested.
// - Write strobe falls when the bus starts driving write data onto the data pins, and also in power-down, where the data pins float.
// - Write strobe pulses on every program, data and I/O write and floats on reset and float.
// - Write/read is always the inverse of read/write and floats on reset and float.
// - Global data request is asserted for global data accesses and floats on reset/pd/float.
package emb_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // Space codes on the request port; bit index of the matching select
    localparam logic [1:0] SPACE_PROG = 2'h0;
    localparam logic [1:0] SPACE_DATA = 2'h1;
    localparam logic [1:0] SPACE_IO   = 2'h2;
    localparam int         SEL_W      = 3;

    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [SEL_W-1:0]  SEL_IDLE = 3'h7;

    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_HOLD} emb_state_t;

    // Every pad value and its active-low output enable
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              addr_oe_n;
        logic [DATA_W-1:0] data;
        logic              data_oe_n;
        logic [SEL_W-1:0]  sel_n;
        logic              strobe_n;
        logic              rw;
        logic              gdr_n;
        logic              ctl_oe_n;
        logic              wr;
        logic              we_n;
        logic              wrt_oe_n;
    } emb_pins_t;

    // Reset: every pad floats, levels sit at their idle values
    localparam emb_pins_t PINS_RST = '{
        addr: ADDR_RST, addr_oe_n: 1'b1, data: DATA_RST, data_oe_n: 1'b1,
        sel_n: SEL_IDLE, strobe_n: 1'b1, rw: 1'b1, gdr_n: 1'b1, ctl_oe_n: 1'b1,
        wr: 1'b0, we_n: 1'b1, wrt_oe_n: 1'b1};

endpackage : emb_pkg

// >>> shared/emb_pin_if.sv
// Carrier between the bus sequencer and its pad register stage
`timescale 1ns/10ps
interface emb_pin_if;
    emb_pkg::emb_pins_t next_pins;
    emb_pkg::emb_pins_t pins;

    modport seq (output next_pins, input pins);
    modport pad (input next_pins, output pins);
endinterface : emb_pin_if

// >>> hw/emb_pad_reg.sv
// Pad register stage: every bus pin and enable leaves the chip from a flip-flop
`timescale 1ns/10ps
module emb_pad_reg (
    input  wire logic clk_in,
    input  wire logic srst_in,
    emb_pin_if.pad    pin_if
);
    emb_pkg::emb_pins_t q;
    emb_pkg::emb_pins_t next_q;

    // Next value is the sequencer's decision
    always_comb
    begin
        next_q = pin_if.next_pins;
    end

    // Reset floats every pad, which covers reset floating of all groups
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            q <= emb_pkg::PINS_RST;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign pin_if.pins = q;
endmodule : emb_pad_reg

// >>> hw/emb_bus.sv
// External memory and I/O bus sequencer with wait states and pad float control
`timescale 1ns/10ps
module emb_bus #(
    parameter int ADDR_W = emb_pkg::ADDR_W,
    parameter int DATA_W = emb_pkg::DATA_W
) (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              power_down_in,
    input  wire logic              float_req_n_in,
    input  wire logic              req_in,
    input  wire logic              req_write_in,
    input  wire logic [1:0]        req_space_in,
    input  wire logic              req_global_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [DATA_W-1:0] req_wdata_in,
    output logic                   req_ready_out,
    output logic                   done_out,
    output logic [DATA_W-1:0]      rdata_out,
    input  wire logic              ready_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic [ADDR_W-1:0]      addr_out,
    output logic                   addr_oe_n_out,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe_n_out,
    output logic                   program_space_select_n_out,
    output logic                   data_space_select_n_out,
    output logic                   io_space_select_n_out,
    output logic                   select_oe_n_out,
    output logic                   access_strobe_n_out,
    output logic                   access_strobe_oe_n_out,
    output logic                   rw_out,
    output logic                   rw_oe_n_out,
    output logic                   global_data_request_n_out,
    output logic                   global_data_request_oe_n_out,
    output logic                   wr_out,
    output logic                   wr_oe_n_out,
    output logic                   write_strobe_n_out,
    output logic                   write_strobe_oe_n_out
);
    // The pad struct is fixed at the package widths
    if (ADDR_W != emb_pkg::ADDR_W || DATA_W != emb_pkg::DATA_W)
    begin : g_width_check
        $error("emb_bus: bus widths must match the package");
    end

    typedef struct packed {
        emb_pkg::emb_state_t st;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic                write;
        logic [1:0]          space;
        logic                global_req;
        logic [DATA_W-1:0]   rdata;
        logic                done;
        logic                ready;
    } emb_core_t;

    emb_core_t q;
    emb_core_t next_q;
    emb_pin_if pin_if ();

    logic accept;
    logic active;
    logic floated;

    // Requests stop while the pads are floated, since no cycle could be seen outside
    always_comb
    begin
        floated = power_down_in || !float_req_n_in;
        accept  = req_in && q.ready;
        next_q  = q;
        next_q.done = 1'b0;
        case (q.st)
            emb_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    next_q.st         = emb_pkg::ST_ACCESS;
                    next_q.addr       = req_addr_in;
                    next_q.wdata      = req_wdata_in;
                    next_q.write      = req_write_in;
                    next_q.space      = req_space_in;
                    next_q.global_req = req_global_in;
                end
            end
            emb_pkg::ST_ACCESS:
            begin
                // Low ready keeps the cycle open one more clock, then looks again
                if (ready_in)
                begin
                    next_q.done = 1'b1;
                    if (q.write)
                    begin
                        next_q.st = emb_pkg::ST_HOLD;
                    end
                    else
                    begin
                        next_q.st    = emb_pkg::ST_IDLE;
                        next_q.rdata = data_in;
                    end
                end
            end
            emb_pkg::ST_HOLD:
            begin
                next_q.st = emb_pkg::ST_IDLE;
            end
            default:
            begin
                next_q.st = emb_pkg::ST_IDLE;
            end
        endcase
        next_q.ready = (next_q.st == emb_pkg::ST_IDLE) && !floated;
    end

    // Core state register
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            q <= '{st: emb_pkg::ST_IDLE, addr: emb_pkg::ADDR_RST,
                   wdata: emb_pkg::DATA_RST, write: 1'b0, space: emb_pkg::SPACE_PROG,
                   global_req: 1'b0, rdata: emb_pkg::DATA_RST, done: 1'b0,
                   ready: 1'b0};
        end
        else
        begin
            q <= next_q;
        end
    end

    // Pads follow the next state so that they change on the same edge as the state
    always_comb
    begin
        active = next_q.st == emb_pkg::ST_ACCESS;
        pin_if.next_pins           = emb_pkg::PINS_RST;
        pin_if.next_pins.addr      = next_q.addr;
        pin_if.next_pins.addr_oe_n = !float_req_n_in;
        pin_if.next_pins.data      = next_q.wdata;
        // Data stays driven one clock past the write strobe rise for hold time
        pin_if.next_pins.data_oe_n = !(next_q.write && next_q.st != emb_pkg::ST_IDLE)
                                     || floated;
        pin_if.next_pins.sel_n = emb_pkg::SEL_IDLE;
        if (active)
        begin
            pin_if.next_pins.sel_n[next_q.space] = 1'b0;
        end
        pin_if.next_pins.strobe_n = !active;
        pin_if.next_pins.rw       = !(active && next_q.write);
        pin_if.next_pins.gdr_n    = !(active && next_q.global_req
                                      && next_q.space == emb_pkg::SPACE_DATA);
        pin_if.next_pins.ctl_oe_n = floated;
        pin_if.next_pins.wr       = active && next_q.write;
        pin_if.next_pins.we_n     = !(active && next_q.write);
        pin_if.next_pins.wrt_oe_n = !float_req_n_in;
    end

    emb_pad_reg u_pad (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .pin_if  (pin_if)
    );

    assign req_ready_out                = q.ready;
    assign done_out                     = q.done;
    assign rdata_out                    = q.rdata;
    assign addr_out                     = pin_if.pins.addr;
    assign addr_oe_n_out                = pin_if.pins.addr_oe_n;
    assign data_out                     = pin_if.pins.data;
    assign data_oe_n_out                = pin_if.pins.data_oe_n;
    assign program_space_select_n_out   = pin_if.pins.sel_n[emb_pkg::SPACE_PROG];
    assign data_space_select_n_out      = pin_if.pins.sel_n[emb_pkg::SPACE_DATA];
    assign io_space_select_n_out        = pin_if.pins.sel_n[emb_pkg::SPACE_IO];
    assign select_oe_n_out              = pin_if.pins.ctl_oe_n;
    assign access_strobe_n_out          = pin_if.pins.strobe_n;
    assign access_strobe_oe_n_out       = pin_if.pins.ctl_oe_n;
    assign rw_out                       = pin_if.pins.rw;
    assign rw_oe_n_out                  = pin_if.pins.ctl_oe_n;
    assign global_data_request_n_out    = pin_if.pins.gdr_n;
    assign global_data_request_oe_n_out = pin_if.pins.ctl_oe_n;
    assign wr_out                       = pin_if.pins.wr;
    assign wr_oe_n_out                  = pin_if.pins.wrt_oe_n;
    assign write_strobe_n_out           = pin_if.pins.we_n;
    assign write_strobe_oe_n_out        = pin_if.pins.wrt_oe_n;

    // Checks on the pads against their causes
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_addr_taken: assert property (accept |=> addr_out == $past(req_addr_in))
        else $error("address not taken from request");
    a_addr_float: assert property (!float_req_n_in |=> addr_oe_n_out)
        else $error("address driven during float request");
    a_addr_pd_hold: assert property (power_down_in && $past(power_down_in)
        |=> $stable(addr_out)) else $error("address moved in power-down");
    a_data_only_write: assert property (!data_oe_n_out |-> !$past(power_down_in)
        && (!rw_out || $past(!rw_out))) else $error("data driven outside a write");
    a_data_pd_float: assert property (power_down_in |=> data_oe_n_out)
        else $error("data driven in power-down");
    a_one_select: assert property ($countones(~{program_space_select_n_out,
        data_space_select_n_out, io_space_select_n_out}) == (access_strobe_n_out ? 0 : 1))
        else $error("select not paired with strobe");
    a_ready_wait: assert property (!access_strobe_n_out && !ready_in
        |=> !access_strobe_n_out && $stable(addr_out) && $stable(rw_out))
        else $error("access ended without ready");
    a_ready_end: assert property (!access_strobe_n_out && ready_in
        |=> access_strobe_n_out) else $error("access did not end on ready");
    a_rw_write: assert property (!rw_out |-> !write_strobe_n_out)
        else $error("read/write low outside a write");
    a_strobe_float: assert property (power_down_in || !float_req_n_in
        |=> access_strobe_oe_n_out && select_oe_n_out && rw_oe_n_out)
        else $error("control driven while floated");
    // A float request at the starting edge floats the data, and the strobe pad with it
    a_we_data: assert property ($fell(write_strobe_n_out) |-> !data_oe_n_out ||
        $past(power_down_in) || !$past(float_req_n_in))
        else $error("write strobe without data");
    a_we_hold: assert property ($rose(write_strobe_n_out) && !$past(power_down_in)
        && $past(float_req_n_in) |-> !data_oe_n_out)
        else $error("data released with write strobe");
    a_we_every: assert property (accept && req_write_in |=> !write_strobe_n_out)
        else $error("write strobe missing");
    a_wr_inverse: assert property (wr_out == !rw_out)
        else $error("write/read not inverse");
    a_gdr_data: assert property (!global_data_request_n_out |->
        !data_space_select_n_out) else $error("global request outside data space");

    c_read_nowait: cover property (accept && !req_write_in ##1 ready_in);
    c_write_wait: cover property (accept && req_write_in ##1 !ready_in ##1 ready_in);
    c_float_idle: cover property (!float_req_n_in && q.st == emb_pkg::ST_IDLE);
    c_pd_access: cover property (power_down_in && q.st == emb_pkg::ST_ACCESS);
endmodule : emb_bus

// >>> sim/emb_mem_model.sv
// Behavioural external memory and I/O device on the far side of the bus
`timescale 1ns/10ps
module emb_mem_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] bus_in,
    input  wire logic        strobe_n_in,
    input  wire logic        rw_in,
    input  wire logic        write_strobe_n_in,
    input  wire logic [3:0]  waits_in,
    output logic             ready_out,
    output logic [15:0]      data_out,
    output logic [15:0]      wr_addr_out,
    output logic [15:0]      wr_data_out
);
    logic [3:0]  wait_cnt  = 4'h0;
    logic [15:0] last_data = 16'h0000;
    logic [15:0] wr_addr   = 16'h0000;

    // Stall each strobed access for the asked number of cycles
    assign ready_out = !(strobe_n_in === 1'b0 && wait_cnt < waits_in);
    // Released bus toggles every cycle so stale data never passes for a read
    assign data_out = (strobe_n_in === 1'b0 && rw_in === 1'b1) ? (addr_in ^ 16'h5AC3)
                                                               : ~last_data;

    // Wait counter clears once ready has been shown
    always @(posedge clk_in)
    begin
        wait_cnt <= (strobe_n_in === 1'b0 && !ready_out) ? wait_cnt + 4'h1 : 4'h0;
        last_data <= data_out;
        if (write_strobe_n_in === 1'b0)
            wr_addr <= addr_in;
    end

    // Capture on the rising write strobe, as a real memory would
    always @(posedge write_strobe_n_in)
    begin
        wr_addr_out <= wr_addr;
        wr_data_out <= bus_in;
    end
endmodule : emb_mem_model

// >>> sim/emb_bus_tb.sv
// Self-checking testbench of the external bus sequencer
`timescale 1ns/10ps
module emb_bus_tb;
    logic        clk_in         = 1'b0;
    logic        srst_in        = 1'b1;
    logic        power_down_in  = 1'b0;
    logic        float_req_n_in = 1'b1;
    logic        req_in         = 1'b0;
    logic        req_write_in   = 1'b0;
    logic [1:0]  req_space_in   = 2'h0;
    logic        req_global_in  = 1'b0;
    logic [15:0] req_addr_in    = 16'h0000;
    logic [15:0] req_wdata_in   = 16'h0000;
    logic [3:0]  waits          = 4'h0;
    int          err_count      = 0;
    int          n_compared     = 0;
    logic        req_ready_out, done_out, ready_in, addr_oe_n_out, data_oe_n_out;
    logic        program_space_select_n_out, data_space_select_n_out, io_space_select_n_out;
    logic        select_oe_n_out, access_strobe_n_out, access_strobe_oe_n_out, rw_out;
    logic        rw_oe_n_out, global_data_request_n_out, global_data_request_oe_n_out;
    logic        wr_out, wr_oe_n_out, write_strobe_n_out, write_strobe_oe_n_out;
    logic [15:0] rdata_out, data_in, addr_out, data_out, mdl_data, wr_addr, wr_data;
    wire  [2:0]  sel_n = {io_space_select_n_out, data_space_select_n_out,
                          program_space_select_n_out};
    wire  [7:0]  oe_n  = {addr_oe_n_out, data_oe_n_out, select_oe_n_out,
                          access_strobe_oe_n_out, rw_oe_n_out, global_data_request_oe_n_out,
                          wr_oe_n_out, write_strobe_oe_n_out};

    // Data pins: the bus drives them while writing, the device otherwise
    assign data_in = (data_oe_n_out === 1'b0) ? data_out : mdl_data;

    emb_bus dut (.clk_in, .srst_in, .power_down_in, .float_req_n_in, .req_in, .req_write_in,
        .req_space_in, .req_global_in, .req_addr_in, .req_wdata_in, .req_ready_out, .done_out,
        .rdata_out, .ready_in, .data_in, .addr_out, .addr_oe_n_out, .data_out, .data_oe_n_out,
        .program_space_select_n_out, .data_space_select_n_out, .io_space_select_n_out,
        .select_oe_n_out, .access_strobe_n_out, .access_strobe_oe_n_out, .rw_out,
        .rw_oe_n_out, .global_data_request_n_out, .global_data_request_oe_n_out, .wr_out,
        .wr_oe_n_out, .write_strobe_n_out, .write_strobe_oe_n_out);

    emb_mem_model mdl (.clk_in, .addr_in(addr_out), .bus_in(data_in),
        .strobe_n_in(access_strobe_n_out), .rw_in(rw_out),
        .write_strobe_n_in(write_strobe_n_out), .waits_in(waits), .ready_out(ready_in),
        .data_out(mdl_data), .wr_addr_out(wr_addr), .wr_data_out(wr_data));

    initial
    begin
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One access; outputs are sampled at rising edges, before that edge's updates land
    task automatic access(input logic wr, input logic [1:0] sp, input logic gl,
                          input logic [15:0] ad, input logic [15:0] wd, input logic [3:0] wt);
        int n;
        int s;
        logic g;
        g = gl && sp == 2'h1;
        s = 0;
        @(posedge clk_in);
        waits <= wt;
        {req_in, req_write_in, req_space_in, req_global_in, req_addr_in, req_wdata_in}
            <= {1'b1, wr, sp, gl, ad, wd};
        // Hold the request until an edge has sampled ready high with it
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (req_ready_out !== 1'b1 && n < 40);
        if (req_ready_out !== 1'b1)
        begin
            err_count++;
            $display("unexpected req_ready: expected 1 seen %b", req_ready_out);
            end_of_test();
        end
        req_in <= 1'b0;
        for (n = 0; n < 40 && done_out !== 1'b1; n++)
        begin
            @(posedge clk_in);
            check("wr_inverse", {15'h0, ~rw_out}, {15'h0, wr_out});
            if (done_out !== 1'b1 && access_strobe_n_out === 1'b0)
            begin
                s++;
                check("addr", ad, addr_out);
                check("select", {13'h0, ~(3'h1 << sp)}, {13'h0, sel_n});
                check("rw", {15'h0, ~wr}, {15'h0, rw_out});
                check("wstrobe", {15'h0, ~wr}, {15'h0, write_strobe_n_out});
                check("data_oe", {15'h0, ~wr}, {15'h0, data_oe_n_out});
                check("gdr", {15'h0, ~g}, {15'h0, global_data_request_n_out});
            end
            else
                check("idle_sel", 16'h0007, {13'h0, sel_n});
        end
        if (done_out !== 1'b1)
        begin
            err_count++;
            $display("unexpected done: expected 1 seen %b", done_out);
            end_of_test();
        end
        check("cycles", {12'h0, wt} + 16'h0002, n[15:0]);
        check("strobes", {12'h0, wt} + 16'h0001, s[15:0]);
        if (wr)
            check("mem_data", wd, wr_data);
        else
            check("rdata", ad ^ 16'h5AC3, rdata_out);
        if (wr)
            check("mem_addr", ad, wr_addr);
    endtask : access

    task automatic t_reads();
        for (int i = 0; i < 3; i++)
            access(1'b0, i[1:0], 1'b0, 16'h8001 << i, 16'h0000, i[3:0]);
    endtask : t_reads

    task automatic t_writes();
        for (int i = 0; i < 3; i++)
            access(1'b1, i[1:0], 1'b0, 16'h00F0 + i[15:0], 16'hC3A0 + i[15:0], 4'h2);
    endtask : t_writes

    task automatic t_global();
        access(1'b0, 2'h1, 1'b1, 16'h7FFF, 16'h0000, 4'h1);
        access(1'b1, 2'h1, 1'b1, 16'h4000, 16'h1234, 4'h0);
        access(1'b1, 2'h2, 1'b1, 16'h0042, 16'hFEDC, 4'h3);
    endtask : t_global

    // Let a level change reach the registered enables, then look at them
    task automatic t_float(input logic fl, input logic pd, input logic [7:0] exp);
        @(posedge clk_in);
        float_req_n_in <= ~fl;
        power_down_in <= pd;
        repeat (3) @(posedge clk_in);
        check("oe_n", {8'h0, exp}, {8'h0, oe_n});
        check("refused", {15'h0, ~(fl | pd)}, {15'h0, req_ready_out});
        check("addr_hold", 16'h0042, addr_out);
    endtask : t_float

    initial
    begin
        repeat (4) @(posedge clk_in);
        check("rst_oe_n", 16'h00FF, {8'h0, oe_n});
        srst_in <= 1'b0;
        t_reads();
        t_writes();
        t_global();
        t_float(1'b0, 1'b0, 8'h40);
        t_float(1'b1, 1'b0, 8'hFF);
        t_float(1'b0, 1'b1, 8'h7C);
        t_float(1'b0, 1'b0, 8'h40);
        access(1'b0, 2'h0, 1'b0, 16'hA5A5, 16'h0000, 4'h4);
        end_of_test();
    end
endmodule : emb_bus_tb
